// ### verilog/ipcb_pkg.sv
// Constants and types for the interrupt priority configuration bank.
// Assumes one 200 MHz clock and a 32-bit Avalon-MM register port.

package ipcb_pkg;

   // ***************************************************
   // Sizes
   // ***************************************************
   localparam int unsigned DATA_W = 32;  // Bus data width
   localparam int unsigned ADDR_W = 8;   // Byte address width
   localparam int unsigned PRIO_W = 16;  // Register width
   localparam int unsigned FIELD_W = 2;  // Priority field width
   localparam int unsigned NUM_SRC = 20; // Sources in this bank
   localparam int unsigned NUM_BANK = 3; // Registers in this bank

   // ***************************************************
   // Register map: word index, byte address is index times four
   // ***************************************************
   localparam logic [ADDR_W-1:0] IDX_FLASH_PLL = 8'h02;
   localparam logic [ADDR_W-1:0] IDX_GPIO_CAN = 8'h03;
   localparam logic [ADDR_W-1:0] IDX_SPI_GPIO = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_FLASH_PLL = IDX_FLASH_PLL << 2;
   localparam logic [ADDR_W-1:0] ADDR_GPIO_CAN = IDX_GPIO_CAN << 2;
   localparam logic [ADDR_W-1:0] ADDR_SPI_GPIO = IDX_SPI_GPIO << 2;

   // Reset value and writable bits of each register
   localparam logic [PRIO_W-1:0] RESET_PRIO = 16'h0000;
   localparam logic [PRIO_W-1:0] WMASK_FLASH_PLL = 16'hffcf;
   localparam logic [PRIO_W-1:0] WMASK_GPIO_CAN = 16'hfffc;
   localparam logic [PRIO_W-1:0] WMASK_SPI_GPIO = 16'hfc3f;

   // ***************************************************
   // Field codes and Avalon answers
   // ***************************************************
   localparam logic [FIELD_W-1:0] CODE_OFF = 2'h0;   // Source disabled
   localparam logic [FIELD_W-1:0] CODE_STEP = 2'h1;  // Code minus this is level
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ***************************************************
   // Source table: bank (0 flash/PLL, 1 GPIO/CAN, 2 serial/GPIO) and LSB
   // ***************************************************
   localparam int unsigned BANK_FP = 0;
   localparam int unsigned BANK_GC = 1;
   localparam int unsigned BANK_SG = 2;
   localparam int unsigned SRC_BANK [NUM_SRC] = '{
      0, 0, 0, 0, 0, 0, 0,
      1, 1, 1, 1, 1, 1, 1,
      2, 2, 2, 2, 2, 2};
   localparam int unsigned SRC_LSB [NUM_SRC] = '{
      14, 12, 10, 8, 6, 2, 0,
      14, 12, 10, 8, 6, 4, 2,
      14, 12, 10, 4, 2, 0};

   // Request presented to arbitration
   typedef struct packed {
      logic active;               // Request is live
      logic [FIELD_W-1:0] level;  // Level 0 to 2
   } ipcb_irq_t;

endpackage

// ### verilog/ipcb_top.sv
// Priority configuration bank: three registers of 2-bit fields and the
// per-source masking and level decode that feeds arbitration.
// Assumes source requests come from logic on ref_clk_in, unsynchronised.
//
// The Avalon-MM slave port was left to the implementer.

`timescale 1ns/10ps
`default_nettype none

module ipcb_top (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic [ipcb_pkg::ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [ipcb_pkg::DATA_W-1:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [ipcb_pkg::DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic [1:0] avs_response_out,
   input wire logic [ipcb_pkg::NUM_SRC-1:0] src_request_in,
   output logic [ipcb_pkg::NUM_SRC-1:0] src_enable_out,
   output ipcb_pkg::ipcb_irq_t [ipcb_pkg::NUM_SRC-1:0] irq_out
);

   // ***************************************************
   // Declarations
   // ***************************************************
   // Priority registers
   logic [ipcb_pkg::PRIO_W-1:0] flash_pll_q;
   logic [ipcb_pkg::PRIO_W-1:0] gpio_can_q;
   logic [ipcb_pkg::PRIO_W-1:0] spi_gpio_q;
   // Bus handshake state
   logic wait_q;
   logic req;
   logic accept;
   logic first;
   // Address decode
   logic sel_fp;
   logic sel_gc;
   logic sel_sg;
   logic hit;
   // Byte-lane mask on the low half word
   logic [ipcb_pkg::PRIO_W-1:0] lane_mask;
   logic [ipcb_pkg::PRIO_W-1:0] rd_mux;
   // All three registers side by side for field lookup
   logic [ipcb_pkg::NUM_BANK*ipcb_pkg::PRIO_W-1:0] bank_vec;
   logic [ipcb_pkg::DATA_W-1:0] readdata_q;
   logic [1:0] response_q;
   logic [ipcb_pkg::NUM_SRC-1:0] enable_q;
   ipcb_pkg::ipcb_irq_t [ipcb_pkg::NUM_SRC-1:0] irq_q;
   logic [ipcb_pkg::FIELD_W-1:0] field [ipcb_pkg::NUM_SRC];

   // Merge write data into a register under lane and writable masks
   function automatic logic [ipcb_pkg::PRIO_W-1:0] merge_word(
      input logic [ipcb_pkg::PRIO_W-1:0] old_val,
      input logic [ipcb_pkg::PRIO_W-1:0] new_val,
      input logic [ipcb_pkg::PRIO_W-1:0] lanes,
      input logic [ipcb_pkg::PRIO_W-1:0] wmask);
      logic [ipcb_pkg::PRIO_W-1:0] m;
      m = lanes & wmask;
      merge_word = (old_val & ~m) | (new_val & m);
   endfunction

   // ***************************************************
   // Bus handshake
   // ***************************************************
   // Read and write never overlap, so either one is a request
   assign req = avs_read_in | avs_write_in;
   // First cycle of a request: wait is still high
   assign first = req & wait_q;
   // Completion edge: master samples wait low here
   assign accept = req & ~wait_q;

   // Wait high by default, low for exactly one cycle per request.
   // Costs one extra cycle but keeps every bus output a flip-flop.
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~first;
      end
   end

   // Word-aligned decode; sub-word address bits must be zero
   always_comb begin
      sel_fp = (avs_address_in == ipcb_pkg::ADDR_FLASH_PLL);
      sel_gc = (avs_address_in == ipcb_pkg::ADDR_GPIO_CAN);
      sel_sg = (avs_address_in == ipcb_pkg::ADDR_SPI_GPIO);
      hit = sel_fp | sel_gc | sel_sg;
   end

   // Only byte lanes 0 and 1 carry register bits
   assign lane_mask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

   // ***************************************************
   // Priority registers
   // ***************************************************
   // Writes land on the completion edge; every field in an enabled
   // byte lane updates together, reserved bits stay zero through the mask
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         flash_pll_q <= ipcb_pkg::RESET_PRIO;
      end else if (accept && avs_write_in && sel_fp) begin
         flash_pll_q <= merge_word(flash_pll_q, avs_writedata_in[15:0], lane_mask,
                                   ipcb_pkg::WMASK_FLASH_PLL);
      end
   end

   // GPIO D-F and CAN sources
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         gpio_can_q <= ipcb_pkg::RESET_PRIO;
      end else if (accept && avs_write_in && sel_gc) begin
         gpio_can_q <= merge_word(gpio_can_q, avs_writedata_in[15:0], lane_mask,
                                  ipcb_pkg::WMASK_GPIO_CAN);
      end
   end

   // Serial channels and GPIO A-C
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         spi_gpio_q <= ipcb_pkg::RESET_PRIO;
      end else if (accept && avs_write_in && sel_sg) begin
         spi_gpio_q <= merge_word(spi_gpio_q, avs_writedata_in[15:0], lane_mask,
                                  ipcb_pkg::WMASK_SPI_GPIO);
      end
   end

   // ***************************************************
   // Read path
   // ***************************************************
   // Registers hold zeros in reserved bits, so reads show zero there
   always_comb begin
      rd_mux = '0;
      if (sel_fp) begin
         rd_mux = flash_pll_q & ipcb_pkg::WMASK_FLASH_PLL;
      end else if (sel_gc) begin
         rd_mux = gpio_can_q & ipcb_pkg::WMASK_GPIO_CAN;
      end else if (sel_sg) begin
         rd_mux = spi_gpio_q & ipcb_pkg::WMASK_SPI_GPIO;
      end
   end

   // Read data captured on the first cycle, valid when wait drops
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         readdata_q <= '0;
      end else if (first) begin
         // Upper half word is not implemented and reads zero
         readdata_q <= avs_read_in ? {16'h0000, rd_mux} : '0;
      end
   end

   // Unmapped addresses answer with a slave error, nothing changes
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         response_q <= ipcb_pkg::RESP_OKAY;
      end else if (first) begin
         response_q <= hit ? ipcb_pkg::RESP_OKAY : ipcb_pkg::RESP_SLVERR;
      end
   end

   assign avs_readdata_out = readdata_q;
   assign avs_response_out = response_q;
   assign avs_waitrequest_out = wait_q;

   // ***************************************************
   // Per-source decode
   // ***************************************************
   assign bank_vec = {spi_gpio_q, gpio_can_q, flash_pll_q};

   // One field per source, picked by bank and bit position
   for (genvar i = 0; i < ipcb_pkg::NUM_SRC; i++) begin : g_src
      localparam int unsigned POS =
         ipcb_pkg::SRC_BANK[i] * ipcb_pkg::PRIO_W + ipcb_pkg::SRC_LSB[i];

      // Field placement per source table
      assign field[i] = bank_vec[POS +: ipcb_pkg::FIELD_W];

      // Enable and request registered so outputs are glitch free;
      // costs one cycle of latency from request to arbitration
      always_ff @(posedge ref_clk_in) begin
         if (reset_in) begin
            enable_q[i] <= 1'b0;
            irq_q[i] <= '0;
         end else begin
            enable_q[i] <= (field[i] != ipcb_pkg::CODE_OFF);
            // Disabled sources are masked, level parked at zero
            if (src_request_in[i] && field[i] != ipcb_pkg::CODE_OFF) begin
               irq_q[i].active <= 1'b1;
               irq_q[i].level <= field[i] - ipcb_pkg::CODE_STEP;
            end else begin
               irq_q[i].active <= 1'b0;
               irq_q[i].level <= '0;
            end
         end
      end

      // Live request carries code minus one as its level
      property p_src_decode;
         @(posedge ref_clk_in) disable iff (reset_in)
         irq_q[i].active |-> ($past(src_request_in[i]) &&
            irq_q[i].level == $past(field[i]) - ipcb_pkg::CODE_STEP);
      endproperty
      a_src_decode: assert property (p_src_decode)
         else $error("Source level does not match its field");

      // A zero field masks the request on the next cycle
      property p_src_mask;
         @(posedge ref_clk_in) disable iff (reset_in)
         (field[i] == ipcb_pkg::CODE_OFF) |=> !irq_q[i].active && !enable_q[i];
      endproperty
      a_src_mask: assert property (p_src_mask)
         else $error("Disabled source reached arbitration");

      // An enabled live request is forwarded on the next cycle
      property p_src_present;
         @(posedge ref_clk_in) disable iff (reset_in)
         (src_request_in[i] && field[i] != ipcb_pkg::CODE_OFF) |=> irq_q[i].active;
      endproperty
      a_src_present: assert property (p_src_present)
         else $error("Enabled request not forwarded");

      // Level never shows the unused code three
      property p_src_level;
         @(posedge ref_clk_in) disable iff (reset_in)
         irq_q[i].level != 2'h3;
      endproperty
      a_src_level: assert property (p_src_level)
         else $error("Source level outside 0 to 2");

      // A non-zero field enables its source on the next cycle
      property p_src_enable;
         @(posedge ref_clk_in) disable iff (reset_in)
         (field[i] != ipcb_pkg::CODE_OFF) |=> enable_q[i];
      endproperty
      a_src_enable: assert property (p_src_enable)
         else $error("Non-zero field did not enable its source");
   end

   assign src_enable_out = enable_q;
   assign irq_out = irq_q;

   // ***************************************************
   // Assertions
   // ***************************************************
   // All fields clear one cycle into reset; no look back at the first edge
   property p_reset_clear;
      @(posedge ref_clk_in)
      reset_in |=> (bank_vec == '0 && irq_q == '0);
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("Priority fields not clear after reset");

   // Reserved bits never become set
   property p_reserved_zero;
      @(posedge ref_clk_in) disable iff (reset_in)
      (flash_pll_q[5:4] == 2'h0) && (gpio_can_q[1:0] == 2'h0) &&
      (spi_gpio_q[9:6] == 4'h0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("Reserved priority bits became set");

   // Full write to flash/PLL lands in one cycle
   property p_write_fp;
      @(posedge ref_clk_in) disable iff (reset_in)
      (accept && avs_write_in && sel_fp && avs_byteenable_in[1:0] == 2'h3) |=>
      flash_pll_q == ($past(avs_writedata_in[15:0]) & ipcb_pkg::WMASK_FLASH_PLL);
   endproperty
   a_write_fp: assert property (p_write_fp)
      else $error("Flash/PLL write did not land whole");

   // Full write to GPIO/CAN lands in one cycle
   property p_write_gc;
      @(posedge ref_clk_in) disable iff (reset_in)
      (accept && avs_write_in && sel_gc && avs_byteenable_in[1:0] == 2'h3) |=>
      gpio_can_q == ($past(avs_writedata_in[15:0]) & ipcb_pkg::WMASK_GPIO_CAN);
   endproperty
   a_write_gc: assert property (p_write_gc)
      else $error("GPIO/CAN write did not land whole");

   // Full write to serial/GPIO lands in one cycle
   property p_write_sg;
      @(posedge ref_clk_in) disable iff (reset_in)
      (accept && avs_write_in && sel_sg && avs_byteenable_in[1:0] == 2'h3) |=>
      spi_gpio_q == ($past(avs_writedata_in[15:0]) & ipcb_pkg::WMASK_SPI_GPIO);
   endproperty
   a_write_sg: assert property (p_write_sg)
      else $error("Serial/GPIO write did not land whole");

   // Register value is stable without an accepted write
   property p_hold;
      @(posedge ref_clk_in) disable iff (reset_in)
      !(accept && avs_write_in) |=> $stable(bank_vec);
   endproperty
   a_hold: assert property (p_hold)
      else $error("Priority register changed without a write");

   // Wait drops exactly one cycle after a request starts, then rises
   property p_wait_one;
      @(posedge ref_clk_in) disable iff (reset_in)
      first |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("Wait request not low for exactly one cycle");

   // Read data at completion shows the GPIO/CAN register
   property p_read_gc;
      @(posedge ref_clk_in) disable iff (reset_in)
      (first && avs_read_in && sel_gc) |=>
      avs_readdata_out == {16'h0000, $past(gpio_can_q)};
   endproperty
   a_read_gc: assert property (p_read_gc)
      else $error("GPIO/CAN read data wrong");

   // Read data at completion shows the flash/PLL register
   property p_read_fp;
      @(posedge ref_clk_in) disable iff (reset_in)
      (first && avs_read_in && sel_fp) |=>
      avs_readdata_out == {16'h0000, $past(flash_pll_q)};
   endproperty
   a_read_fp: assert property (p_read_fp)
      else $error("Flash/PLL read data wrong");

   // Read data at completion shows the serial/GPIO register
   property p_read_sg;
      @(posedge ref_clk_in) disable iff (reset_in)
      (first && avs_read_in && sel_sg) |=>
      avs_readdata_out == {16'h0000, $past(spi_gpio_q)};
   endproperty
   a_read_sg: assert property (p_read_sg)
      else $error("Serial/GPIO read data wrong");

   // Unmapped access answers with an error and zero data
   property p_unmapped;
      @(posedge ref_clk_in) disable iff (reset_in)
      (first && !hit) |=>
      (avs_response_out == ipcb_pkg::RESP_SLVERR) && (avs_readdata_out == '0);
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("Unmapped access did not answer with an error");

   // Scenario coverage
   c_write_fp: cover property (@(posedge ref_clk_in) accept && avs_write_in && sel_fp);
   c_read_sg: cover property (@(posedge ref_clk_in) accept && avs_read_in && sel_sg);
   c_unmapped: cover property (@(posedge ref_clk_in) accept && !hit);
   c_level_two: cover property (@(posedge ref_clk_in) irq_q[0].active &&
      irq_q[0].level == 2'h2);

endmodule

`default_nettype wire

// ### tb/ipcb_src_model.sv
// Model of the peripheral request lines that feed the priority bank.
// Assumes the bench names the wanted request pattern; lines move on edges only.

`timescale 1ns/10ps
`default_nettype none

module ipcb_src_model (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic [ipcb_pkg::NUM_SRC-1:0] pattern_in,
   output logic [ipcb_pkg::NUM_SRC-1:0] src_request_out
);

   // ***************************************************
   // Request lines
   // ***************************************************
   // Launched from a flop, as a clocked peripheral would do
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         src_request_out <= '0; // Peripherals quiet in reset
      end else begin
         src_request_out <= pattern_in; // Level held as long as asked
      end
   end

endmodule

`default_nettype wire

// ### tb/irq_priority_config_bank_tb.sv
// Self-checking bench for the priority bank: bus tasks plus source model.
// Assumes an Avalon slave that may insert wait states; the master waits them out.

`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin errors++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end

module irq_priority_config_bank_tb;

   // ***************************************************
   // Signals and tables
   // ***************************************************
   logic ref_clk_in = 1'b0;
   logic reset_in = 1'b1; // Held for 4 cycles at start
   logic [7:0] avs_address_in = 8'h00;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h00000000;
   logic [3:0] avs_byteenable_in = 4'h0;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic [1:0] avs_response_out;
   logic [19:0] pattern = 20'h00000; // Wanted request lines
   logic [19:0] src_request_in;
   logic [19:0] src_enable_out;
   ipcb_pkg::ipcb_irq_t [19:0] irq_out;
   int errors = 0;
   int num_checks = 0;
   // Register addresses and writable bits, worked out by hand
   logic [7:0] badr [3] = '{8'h08, 8'h0c, 8'h10};
   logic [15:0] bmsk [3] = '{16'hffcf, 16'hfffc, 16'hfc3f};
   // Register and field position of each source
   int sbank [20] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2};
   int slsb [20] = '{14, 12, 10, 8, 6, 2, 0, 14, 12, 10, 8, 6, 4, 2, 14, 12, 10, 4, 2, 0};
   logic [31:0] rd;
   logic [1:0] rs;

   // Free-running 200 MHz clock
   initial begin
      forever #2.5 ref_clk_in = ~ref_clk_in;
   end

   ipcb_top i_dut (
      .ref_clk_in(ref_clk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .avs_response_out(avs_response_out), .src_request_in(src_request_in),
      .src_enable_out(src_enable_out), .irq_out(irq_out));

   ipcb_src_model i_src (
      .ref_clk_in(ref_clk_in), .reset_in(reset_in), .pattern_in(pattern),
      .src_request_out(src_request_in));

   // ***************************************************
   // Tasks
   // ***************************************************
   // One bus cycle; an idle edge first so strobes are never set twice at once
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      @(posedge ref_clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_byteenable_in <= be;
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      // Hold everything until wait is seen low; only the watchdog ends a hang
      do begin
         @(posedge ref_clk_in);
      end while (avs_waitrequest_out !== 1'b0);
      rd = avs_readdata_out;
      rs = avs_response_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask

   // Read and compare data and response
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      bus(1'b0, a, 32'h00000000, 4'h0);
      `CHK("readdata", exp, rd)
      `CHK("response", er, rs)
   endtask

   // Let register and request changes reach the registered outputs
   task automatic settle();
      repeat (3) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
   endtask

   // Expected request of one source from its code and request line
   task automatic src_chk(input int i, input logic [1:0] c);
      logic [2:0] e;
      e = (c != 2'h0 && pattern[i]) ? {1'b1, c - 2'h1} : 3'h0;
      `CHK("irq_out", e, irq_out[i])
      `CHK("src_enable", c != 2'h0, src_enable_out[i])
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ***************************************************
   // Tests
   // ***************************************************
   initial begin
      logic [15:0] f;
      repeat (4) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      // Reset state: every field off
      for (int b = 0; b < 3; b++) begin
         rd_chk(badr[b], 32'h00000000, 2'h0);
      end
      `CHK("enables", 20'h00000, src_enable_out)
      $display("test reset done");
      // Every code in every field, one write per register
      pattern <= 20'hfffff;
      for (int c = 0; c < 4; c++) begin
         f = {8{c[1:0]}};
         for (int b = 0; b < 3; b++) begin
            bus(1'b1, badr[b], {16'hffff, f}, 4'hf);
         end
         settle();
         for (int b = 0; b < 3; b++) begin
            rd_chk(badr[b], {16'h0000, f & bmsk[b]}, 2'h0);
         end
         for (int i = 0; i < 20; i++) begin
            src_chk(i, c[1:0]);
         end
      end
      // Fields live but some requests low: those stay masked
      pattern <= 20'h0f0f0;
      settle();
      for (int i = 0; i < 20; i++) begin
         src_chk(i, 2'h3);
      end
      $display("test decode done");
      // Field position of each source, one at a time
      pattern <= 20'hfffff;
      for (int b = 0; b < 3; b++) begin
         bus(1'b1, badr[b], 32'h00000000, 4'h3);
      end
      for (int i = 0; i < 20; i++) begin
         bus(1'b1, badr[sbank[i]], 32'(2'h2) << slsb[i], 4'h3);
         settle();
         `CHK("enables", 20'h00001 << i, src_enable_out)
         src_chk(i, 2'h2);
         rd_chk(badr[sbank[i]], 32'(2'h2) << slsb[i], 2'h0);
         bus(1'b1, badr[sbank[i]], 32'h00000000, 4'h3);
      end
      $display("test mapping done");
      // Byte lanes write separately
      bus(1'b1, badr[0], 32'hffffffff, 4'h2);
      rd_chk(badr[0], 32'h0000ff00, 2'h0);
      bus(1'b1, badr[0], 32'hffffffff, 4'h1);
      rd_chk(badr[0], 32'h0000ffcf, 2'h0);
      // Unmapped place: error answer, no side effect
      bus(1'b1, 8'h00, 32'hffffffff, 4'hf);
      rd_chk(8'h00, 32'h00000000, 2'h2);
      rd_chk(badr[0], 32'h0000ffcf, 2'h0);
      rd_chk(badr[1], 32'h00000000, 2'h0);
      rd_chk(badr[2], 32'h00000000, 2'h0);
      $display("test bus done");
      // Reset in mid-run clears fields set before it
      bus(1'b1, badr[2], 32'h0000ffff, 4'h3);
      settle();
      @(posedge ref_clk_in);
      reset_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      settle();
      `CHK("enables", 20'h00000, src_enable_out)
      `CHK("irq_out", 60'h0, irq_out)
      for (int b = 0; b < 3; b++) begin
         rd_chk(badr[b], 32'h00000000, 2'h0);
      end
      $display("test reset again done");
      end_of_test();
   end

   // Watchdog well past the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      errors++;
      end_of_test();
   end

endmodule

`default_nettype wire
